// ===== src/vmeint_map.svh
// Purpose: Register offsets, field positions and reset values of the backplane interrupter.
// Assumes: Byte addresses on a 32-bit register bus, one register per aligned word.
// Notes: Definitions only; included by the cycle decoder and the top module.
`ifndef VMEINT_MAP_SVH
`define VMEINT_MAP_SVH

// Byte offset of the interrupt control register.
`define VMEINT_OFS_CTRL 4'h0
// Byte offset of the Status/ID register.
`define VMEINT_OFS_VECT 4'h4
// Position of the request enable bit in the control register.
`define VMEINT_CTRL_EN_BIT 3
// Low bit and high bit of the level field in the control register.
`define VMEINT_CTRL_LVL_LO 0
`define VMEINT_CTRL_LVL_HI 2
// Reset value of the control register: no level, request disabled.
`define VMEINT_CTRL_RST 4'h0
// Reset value of the Status/ID register.
`define VMEINT_VECT_RST 8'h00
// Level code that means no backplane level is selected.
`define VMEINT_LVL_NONE 3'h0
// Value of the cycle class bits that marks a CPU space cycle.
`define VMEINT_FC_CPU 3'h7
// Upper address nibble of an interrupt acknowledge and of a breakpoint cycle.
`define VMEINT_AHI_IACK 4'hF
`define VMEINT_AHI_BRKPT 4'h0

`endif

// ===== src/vmeint_pkg.sv
// Purpose: Types shared by the backplane interrupter files.
// Assumes: Constants live in vmeint_map.svh.
// Notes: Nothing here is imported; users write vmeint_pkg::name.
package vmeint_pkg;

  // Contents of the interrupt control register.
  typedef struct packed {
    logic en;
    logic [2:0] level;
  } vmeint_ctrl_s;

  // Backplane acknowledge inputs after synchronisation.
  typedef struct packed {
    logic iack_n;
    logic iackin_n;
    logic as_n;
    logic ds0_n;
    logic [2:0] lvl;
  } vmeint_vme_s;

  // Local processor cycle inputs after synchronisation.
  typedef struct packed {
    logic as_n;
    logic [2:0] fc;
    logic [3:0] ahi;
  } vmeint_cpu_s;

  // Acknowledge sequencer states, one-hot.
  typedef enum logic [2:0] {
    VMEINT_IDLE = 3'b001,
    VMEINT_MINE = 3'b010,
    VMEINT_PASS = 3'b100
  } vmeint_state_e;

endpackage

// ===== src/vmeint_cpu_dec.sv
// Purpose: Classifies a local processor bus cycle as CPU space, acknowledge or breakpoint.
// Assumes: Inputs are already synchronised; purely combinational.
// Notes: The caller registers the results.
`timescale 1ns/1ps
`include "vmeint_map.svh"
module vmeint_cpu_dec (
  // Cycle class lines and upper address nibble.
  input wire logic [2:0] fc_in,
  input wire logic [3:0] ahi_in,
  // Decoded cycle kinds.
  output logic cpu_space_out,
  output logic iack_cycle_out,
  output logic brkpt_cycle_out
);

  // A CPU space cycle has all three class lines high.
  assign cpu_space_out = (fc_in == `VMEINT_FC_CPU);
  // An acknowledge is a CPU space cycle with the nibble all high.
  assign iack_cycle_out = cpu_space_out && (ahi_in == `VMEINT_AHI_IACK);
  // A breakpoint is a CPU space cycle with the nibble all low.
  assign brkpt_cycle_out = cpu_space_out && (ahi_in == `VMEINT_AHI_BRKPT);

endmodule

// ===== src/vmeint_top.sv
// Purpose: Backplane interrupter with Avalon-MM register access and local cycle decode.
// Assumes: All backplane and processor pins are asynchronous to clock_in.
// Notes: Open-drain lines are driven low whenever their enable is high.
//
// Design decisions made here: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`include "vmeint_map.svh"
module vmeint_top (
  // Clock and reset.
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // Avalon-MM register slave.
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Backplane interrupt request lines 1 to 7, open drain.
  output logic [7:1] vme_irq_n_out,
  output logic [7:1] vme_irq_oe_out,
  // Backplane acknowledge inputs.
  input wire logic vme_iack_n_in,
  input wire logic vme_iackin_n_in,
  input wire logic vme_as_n_in,
  input wire logic vme_ds0_n_in,
  input wire logic [2:0] vme_addr_lvl_in,
  // Backplane acknowledge answers.
  output logic [7:0] vme_data_out,
  output logic vme_data_oe_out,
  output logic vme_dtack_n_out,
  output logic vme_dtack_oe_out,
  output logic vme_iackout_n_out,
  // Local processor cycle inputs.
  input wire logic cpu_as_n_in,
  input wire logic [2:0] cpu_fc_in,
  input wire logic [3:0] cpu_addr_hi_in,
  // Local cycle classification.
  output logic cpu_space_out,
  output logic cpu_iack_cycle_out,
  output logic cpu_brkpt_cycle_out
);

  // Two-stage synchronisers for backplane and processor pins.
  vmeint_pkg::vmeint_vme_s vme_s1_q; // First stage, read only by the second.
  vmeint_pkg::vmeint_vme_s vme_q; // Stable backplane inputs.
  vmeint_pkg::vmeint_cpu_s cpu_s1_q; // First stage, read only by the second.
  vmeint_pkg::vmeint_cpu_s cpu_q; // Stable processor inputs.

  // Register file.
  vmeint_pkg::vmeint_ctrl_s ctrl_q; // Level and request enable.
  logic [7:0] vect_q; // Status/ID byte.

  // Bus handshake.
  logic bus_ack_q; // High in the cycle the request completes.
  logic [31:0] rdata_q; // Read data, valid when the request completes.
  logic wr_take; // A write completes this cycle.
  logic wr_ctrl; // Write to the control register low byte.
  logic wr_vect; // Write to the Status/ID register low byte.

  // Acknowledge sequencer.
  vmeint_pkg::vmeint_state_e state_q; // Current sequencer state.
  logic ack_seen; // A daisy-chain acknowledge has reached this board.
  logic ack_match; // The acknowledge is for our pending level.
  logic ack_take; // Our request is being acknowledged now.
  logic [7:0] data_q; // Status/ID byte driven onto the backplane.
  logic data_oe_q; // Drives the data lines.
  logic dtack_q; // Drives the transfer acknowledge line.
  logic iackout_n_q; // Daisy-chain output.
  logic [7:1] irq_oe_q; // Request line enables.

  // Local decode.
  logic dec_space; // Combinational CPU space flag.
  logic dec_iack; // Combinational acknowledge flag.
  logic dec_brk; // Combinational breakpoint flag.
  logic space_q; // Registered CPU space flag.
  logic iack_q; // Registered acknowledge flag.
  logic brk_q; // Registered breakpoint flag.

  // Both synchronisers run on every edge; the first stage feeds the second only.
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      vme_s1_q <= '1;
      vme_q <= '1;
      cpu_s1_q <= '1;
      cpu_q <= '1;
    end else begin
      vme_s1_q <= {vme_iack_n_in, vme_iackin_n_in, vme_as_n_in, vme_ds0_n_in, vme_addr_lvl_in};
      vme_q <= vme_s1_q;
      cpu_s1_q <= {cpu_as_n_in, cpu_fc_in, cpu_addr_hi_in};
      cpu_q <= cpu_s1_q;
    end
  end

  // Every request waits one cycle, so read data can come from a flip-flop.
  assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !bus_ack_q;
  assign wr_take = avs_write_in && bus_ack_q;
  assign wr_ctrl = wr_take && avs_byteenable_in[0] && (avs_address_in[3:2] == 2'(`VMEINT_OFS_CTRL >> 2));
  assign wr_vect = wr_take && avs_byteenable_in[0] && (avs_address_in[3:2] == 2'(`VMEINT_OFS_VECT >> 2));
  assign avs_readdata_out = rdata_q;

  // Completion pulse follows the first cycle of each request.
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      bus_ack_q <= 1'b0;
    end else begin
      bus_ack_q <= (avs_read_in || avs_write_in) && !bus_ack_q;
    end
  end

  // Read data is captured in the wait cycle; unmapped words read zero.
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      rdata_q <= 32'h00000000;
    end else if (avs_read_in && !bus_ack_q) begin
      if (avs_address_in[3:2] == 2'(`VMEINT_OFS_CTRL >> 2)) begin
        // Pending bits are visible so software can check for an idle interrupter.
        rdata_q <= {28'h0000000, ctrl_q};
      end else if (avs_address_in[3:2] == 2'(`VMEINT_OFS_VECT >> 2)) begin
        rdata_q <= {24'h000000, vect_q};
      end else begin
        rdata_q <= 32'h00000000;
      end
    end
  end

  // Control register: a software write beats the clear from an acknowledge.
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      ctrl_q <= `VMEINT_CTRL_RST;
    end else if (wr_ctrl) begin
      // Level first with enable low, enable high only in the final write.
      ctrl_q <= avs_writedata_in[`VMEINT_CTRL_EN_BIT:`VMEINT_CTRL_LVL_LO];
    end else if (ack_take) begin
      // Release on acknowledge: clearing the register drops the request.
      ctrl_q <= `VMEINT_CTRL_RST;
    end
  end

  // Status/ID register is only ever changed by software.
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      vect_q <= `VMEINT_VECT_RST;
    end else if (wr_vect) begin
      vect_q <= avs_writedata_in[7:0];
    end
  end

  // Request line enables follow the control register.
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      irq_oe_q <= 7'h00;
    end else begin
      for (int i = 1; i <= 7; i++) begin
        // Only the selected line, and only while enabled.
        irq_oe_q[i] <= ctrl_q.en && (ctrl_q.level == 3'(i));
      end
    end
  end
  assign vme_irq_oe_out = irq_oe_q;
  // Open-drain: the level driven is always low.
  assign vme_irq_n_out = 7'h00;

  // An acknowledge for this board needs the chain input, strobes and acknowledge line.
  assign ack_seen = !vme_q.iack_n && !vme_q.iackin_n && !vme_q.as_n && !vme_q.ds0_n;
  // Our own local handler is a legal acknowledger; no source is excluded.
  assign ack_match = ctrl_q.en && (vme_q.lvl == ctrl_q.level);
  assign ack_take = (state_q == vmeint_pkg::VMEINT_IDLE) && ack_seen && ack_match;

  // Acknowledge sequencer.
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      state_q <= vmeint_pkg::VMEINT_IDLE;
    end else begin
      unique case (state_q)
        vmeint_pkg::VMEINT_IDLE: begin
          // Answer our own level, hand everything else down the chain.
          if (ack_take) begin
            state_q <= vmeint_pkg::VMEINT_MINE;
          end else if (ack_seen) begin
            state_q <= vmeint_pkg::VMEINT_PASS;
          end
        end
        vmeint_pkg::VMEINT_MINE: begin
          // Hold the answer until the handler lifts its data strobe.
          if (vme_q.ds0_n) begin
            state_q <= vmeint_pkg::VMEINT_IDLE;
          end
        end
        vmeint_pkg::VMEINT_PASS: begin
          // Hold the chain open until the address strobe ends the cycle.
          if (vme_q.as_n) begin
            state_q <= vmeint_pkg::VMEINT_IDLE;
          end
        end
        default: begin
          state_q <= vmeint_pkg::VMEINT_IDLE;
        end
      endcase
    end
  end

  // Status/ID byte is latched at the acknowledge so a later write cannot tear it.
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      data_q <= 8'h00;
      data_oe_q <= 1'b0;
    end else if (ack_take) begin
      data_q <= vect_q;
      data_oe_q <= 1'b1;
    end else if (state_q != vmeint_pkg::VMEINT_MINE) begin
      data_oe_q <= 1'b0;
    end else if (vme_q.ds0_n) begin
      data_oe_q <= 1'b0;
    end
  end

  // Transfer acknowledge follows the data by one cycle for setup.
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      dtack_q <= 1'b0;
    end else begin
      dtack_q <= (state_q == vmeint_pkg::VMEINT_MINE) && !vme_q.ds0_n;
    end
  end

  // Daisy-chain output is low only while passing an acknowledge on.
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      iackout_n_q <= 1'b1;
    end else begin
      iackout_n_q <= !((state_q == vmeint_pkg::VMEINT_PASS) && !vme_q.as_n);
    end
  end

  assign vme_data_out = data_q;
  assign vme_data_oe_out = data_oe_q;
  assign vme_dtack_n_out = 1'b0;
  assign vme_dtack_oe_out = dtack_q;
  assign vme_iackout_n_out = iackout_n_q;

  // Local cycle classification logic.
  vmeint_cpu_dec u_dec (
    .fc_in(cpu_q.fc),
    .ahi_in(cpu_q.ahi),
    .cpu_space_out(dec_space),
    .iack_cycle_out(dec_iack),
    .brkpt_cycle_out(dec_brk)
  );

  // Classification is registered and valid only while the processor strobe is low.
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      space_q <= 1'b0;
      iack_q <= 1'b0;
      brk_q <= 1'b0;
    end else begin
      space_q <= dec_space && !cpu_q.as_n;
      iack_q <= dec_iack && !cpu_q.as_n;
      brk_q <= dec_brk && !cpu_q.as_n;
    end
  end
  assign cpu_space_out = space_q;
  assign cpu_iack_cycle_out = iack_q;
  assign cpu_brkpt_cycle_out = brk_q;

  // Checks on the design's own outputs.
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);

  // At most one request line is ever driven.
  chk_single_level: assert property ($onehot0(irq_oe_q))
    else $error("more than one request line driven");

  // A request line only rises after an enabled control write.
  chk_enable_write: assert property ($rose(|irq_oe_q) |-> $past(ctrl_q.en) && $past(wr_ctrl, 2)
    && $past(avs_writedata_in[`VMEINT_CTRL_EN_BIT], 2))
    else $error("request raised without enabled control write");

  // Accepting an acknowledge drops the request two cycles later and answers within three cycles.
  chk_ack_release: assert property (ack_take && !wr_ctrl |-> ##2 (irq_oe_q == 7'h00)
    ##[0:1] (dtack_q || vme_q.ds0_n))
    else $error("acknowledge not released or not answered");

  // The byte on the data lines is the Status/ID byte held at the acknowledge.
  chk_vector_out: assert property (ack_take |=> data_oe_q && (data_q == $past(vect_q)))
    else $error("wrong Status/ID byte driven");

  // Control register reads zero after an acknowledge without a racing write.
  chk_ctrl_clear: assert property (ack_take && !wr_ctrl |=> ctrl_q == `VMEINT_CTRL_RST)
    else $error("control register not cleared by acknowledge");

  // CPU space flag follows the class lines one cycle later.
  chk_cpu_space: assert property (space_q == ($past(cpu_q.fc) == `VMEINT_FC_CPU && !$past(cpu_q.as_n)))
    else $error("CPU space decode wrong");

  // Acknowledge and breakpoint flags are exclusive and tied to the nibble.
  chk_cycle_class: assert property ((iack_q |-> space_q && $past(cpu_q.ahi) == `VMEINT_AHI_IACK)
    and (brk_q |-> space_q && $past(cpu_q.ahi) == `VMEINT_AHI_BRKPT))
    else $error("acknowledge or breakpoint decode wrong");

  // Any matching acknowledge, our own handler included, is answered.
  chk_self_ack: assert property ((state_q == vmeint_pkg::VMEINT_IDLE) && ack_seen && ack_match
    |=> state_q == vmeint_pkg::VMEINT_MINE)
    else $error("matching acknowledge not taken");

  // A foreign acknowledge is passed on and never answered.
  chk_chain_pass: assert property ((state_q == vmeint_pkg::VMEINT_IDLE) && ack_seen && !ack_match
    |=> ##1 !vme_iackout_n_out && !dtack_q && !data_oe_q)
    else $error("foreign acknowledge not passed on");

endmodule

// ===== dv/vmeint_handler.sv
// Purpose: Behavioural backplane interrupt handler that runs acknowledge cycles.
// Assumes: The bench calls the ack task; signals change just after a rising edge.
// Notes: Released level lines show the inverse of the last code, never a stale value.
`timescale 1ns/1ps
module vmeint_handler (
  // Clock.
  input wire logic clock_in,
  // Answers from the interrupter.
  input wire logic [7:0] data_in,
  input wire logic data_oe_in,
  input wire logic dtack_oe_in,
  input wire logic iackout_n_in,
  // Acknowledge cycle lines, all active low except the level code.
  output logic iack_n_out,
  output logic as_n_out,
  output logic ds0_n_out,
  output logic [2:0] lvl_out,
  // One-cycle pulse with the outcome: pass flag, data enable, data byte.
  output logic res_valid_out,
  output logic [9:0] res_out
);
  // Idle bus at time zero.
  initial begin
    iack_n_out = 1'b1;
    as_n_out = 1'b1;
    ds0_n_out = 1'b1;
    lvl_out = 3'h0;
    res_valid_out = 1'b0;
    res_out = 10'h000;
  end

  // One acknowledge cycle at a level; hold keeps the data strobe low longer.
  task automatic ack(input logic [2:0] lvl, input int hold);
    int n;
    n = 0;
    @(posedge clock_in);
    iack_n_out <= 1'b0;
    as_n_out <= 1'b0;
    ds0_n_out <= 1'b0;
    lvl_out <= lvl;
    // Wait, bounded, for a slave answer or for the chain to be passed on.
    do begin
      @(posedge clock_in);
      n++;
    end while (dtack_oe_in !== 1'b1 && iackout_n_in !== 1'b0 && n < 40);
    // A cycle that neither DTACK nor the chain ended is reported as all ones.
    res_out <= (n >= 40) ? 10'h3FF : (iackout_n_in === 1'b0) ? 10'h200 : {1'b0, data_oe_in, data_in};
    res_valid_out <= 1'b1;
    @(posedge clock_in);
    res_valid_out <= 1'b0;
    repeat (hold) @(posedge clock_in);
    // Release everything; the next cycle needs strobes high first.
    as_n_out <= 1'b1;
    ds0_n_out <= 1'b1;
    iack_n_out <= 1'b1;
    lvl_out <= ~lvl;
    n = 0;
    do begin
      @(posedge clock_in);
      n++;
    end while ((dtack_oe_in !== 1'b0 || iackout_n_in !== 1'b1) && n < 80);
  endtask
endmodule

// ===== dv/tb_vme_interrupter.sv
// Purpose: Self-checking bench for the backplane interrupter.
// Assumes: Avalon reads and acknowledge outcomes are compared through one queue.
// Notes: Random Status/ID bytes and cycle class values come from a fixed seed.
`timescale 1ns/1ps
module tb_vme_interrupter;
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [3:0] be = 4'hF;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdata;
  logic wreq;
  logic [7:1] irq_n;
  logic [7:1] irq_oe;
  logic iack_n, as_n, ds0_n;
  logic [2:0] lvl;
  logic [7:0] vdata;
  logic d_oe, dt_n, dt_oe, iko_n;
  logic c_as_n = 1'b1;
  logic [2:0] fc = 3'h0;
  logic [3:0] ahi = 4'h0;
  logic sp, ia, bk;
  logic rv;
  logic [9:0] res;
  logic [31:0] exp_q[$];
  int n_mismatch = 0;
  int total_checks = 0;

  // 100 MHz clock.
  always #5 clock_in = ~clock_in;

  vmeint_top dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_byteenable_in(be), .avs_writedata_in(wd),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .vme_irq_n_out(irq_n),
    .vme_irq_oe_out(irq_oe), .vme_iack_n_in(iack_n), .vme_iackin_n_in(iack_n),
    .vme_as_n_in(as_n), .vme_ds0_n_in(ds0_n), .vme_addr_lvl_in(lvl), .vme_data_out(vdata),
    .vme_data_oe_out(d_oe), .vme_dtack_n_out(dt_n), .vme_dtack_oe_out(dt_oe),
    .vme_iackout_n_out(iko_n), .cpu_as_n_in(c_as_n), .cpu_fc_in(fc), .cpu_addr_hi_in(ahi),
    .cpu_space_out(sp), .cpu_iack_cycle_out(ia), .cpu_brkpt_cycle_out(bk));

  vmeint_handler hnd (.clock_in(clock_in), .data_in(vdata), .data_oe_in(d_oe),
    .dtack_oe_in(dt_oe), .iackout_n_in(iko_n), .iack_n_out(iack_n), .as_n_out(as_n),
    .ds0_n_out(ds0_n), .lvl_out(lvl), .res_valid_out(rv), .res_out(res));

  // Counts one comparison and reports a mismatch at once.
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  // One Avalon transfer, held until waitrequest is sampled low.
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
    @(posedge clock_in);
    rd <= ~w;
    wr <= w;
    adr <= a;
    wd <= d;
    be <= b;
    // Only the watchdog ends a wait that never sees waitrequest low.
    do begin
      @(posedge clock_in);
    end while (wreq !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  // Read with the expected value noted for the monitor.
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0, 4'hF);
  endtask

  // Acknowledge cycle with the expected outcome noted for the monitor.
  task automatic do_ack(input logic [2:0] l, input int h, input logic [9:0] e);
    exp_q.push_back({22'h0, e});
    hnd.ack(l, h);
  endtask

  // Takes the oldest note whenever read data or an acknowledge outcome appears.
  always @(posedge clock_in) begin
    if ((rd === 1'b1 && wreq === 1'b0) || rv === 1'b1) begin
      if (exp_q.size() == 0) chk(32'hFFFFFFFF, 32'h0);
      else chk(exp_q.pop_front(), (rv === 1'b1) ? {22'h0, res} : rdata);
    end
  end

  // Prints the verdict and ends the run.
  task automatic summarize();
    if (exp_q.size() != 0) n_mismatch++;
    if (n_mismatch == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Cuts a hang short.
  initial begin
    #500000;
    n_mismatch++;
    summarize();
  end

  // Main sequence.
  initial begin
    logic [7:0] v;
    logic [2:0] f;
    logic [3:0] h;
    logic s;
    void'($urandom(41));
    repeat (4) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    rd_chk(4'h0, 32'h0);
    rd_chk(4'h4, 32'h0);
    bus(1'b1, 4'hC, 32'hFF, 4'hF);
    rd_chk(4'hC, 32'h0);
    do_ack(3'h2, 0, 10'h200);
    for (int l = 1; l < 8; l++) begin
      v = 8'($urandom);
      rd_chk(4'h0, 32'h0);
      bus(1'b1, 4'h0, 32'(l), 4'hF);
      bus(1'b1, 4'h4, {24'h0, v}, 4'hF);
      bus(1'b1, 4'h4, {24'h0, ~v}, 4'h0);
      repeat (3) @(posedge clock_in);
      chk(32'h0, {25'h0, irq_oe});
      bus(1'b1, 4'h0, 32'(l) | 32'h8, 4'hF);
      repeat (2) @(posedge clock_in);
      chk(32'h1 << l, {24'h0, irq_oe, 1'b0});
      chk(32'h0, {24'h0, irq_n, dt_n});
      do_ack(3'(l + 1), 0, 10'h200);
      do_ack(3'(l), l[0] ? 6 : 0, {2'b01, v});
      chk(32'h0, {24'h0, irq_oe, 1'b0});
      chk(32'h0, {29'h0, d_oe, dt_oe, ~iko_n});
      rd_chk(4'h0, 32'h0);
      rd_chk(4'h4, {24'h0, v});
    end
    // Local cycle decode over class codes and address nibbles.
    for (int i = 0; i < 16; i++) begin
      f = (i < 10) ? 3'h7 : 3'($urandom);
      h = (i % 3 == 0) ? 4'hF : (i % 3 == 1) ? 4'h0 : 4'($urandom);
      c_as_n <= (i == 15);
      fc <= f;
      ahi <= h;
      repeat (5) @(posedge clock_in);
      s = (i != 15) && (f == 3'h7);
      chk({29'h0, s, s && h == 4'hF, s && h == 4'h0}, {29'h0, sp, ia, bk});
    end
    summarize();
  end
endmodule
